//--- dv/dbh_host_model.sv
// dbh_host_model: host side of the bus handover, plus memory and port read data
// assumes one sys_clk; grant answers request after a machine cycle of cycle_len
`timescale 1ns/1ns
module dbh_host_model #(
  parameter logic [7:0] IO_BYTE = 8'h3c          // peripheral read byte
) (
  // clock and cycle length
  input  wire logic                  sys_clk,
  input  int                         cycle_len,
  // handshake
  input  wire logic                  bus_hold_request_n,
  output logic                       bus_hold_grant_n,
  // system bus as driven by the dma, and read data driven back to it
  input  wire logic [15:0]           addr_o,
  input  wire dbh_pkg::dbh_strobes_t strobes_o,
  input  wire logic                  strobes_oe,
  output logic [7:0]                 data_i
);
  logic [7:0] last_r = 8'ha5;                    // previous bus value

  // ==========================================================
  // grant handshake
  // ==========================================================
  // the host drives no address, data or strobes at all here
  initial begin
    bus_hold_grant_n = 1'b1;
    forever begin
      @(posedge sys_clk);
      if (bus_hold_request_n === 1'b0) begin
        repeat (cycle_len - 1) @(posedge sys_clk); // first edge already seen; finish cycle
        @(posedge sys_clk);
        bus_hold_grant_n <= 1'b0;                // grant one clock later
        while (bus_hold_request_n !== 1'b1) @(posedge sys_clk);
        @(posedge sys_clk);
        bus_hold_grant_n <= 1'b1;                // one clock after write end
      end
    end
  end

  // ==========================================================
  // read data: memory byte from address, port byte IO_BYTE, else a changing pattern
  // ==========================================================
  always @(posedge sys_clk) last_r <= data_i;
  always @* begin
    if (strobes_oe === 1'b1 && strobes_o.rd_n === 1'b0)
      data_i = strobes_o.memory_cycle_strobe_n ? IO_BYTE : addr_o[7:0] ^ 8'h5a;
    else
      data_i = ~last_r;                          // released bus
  end
endmodule

//--- dv/tb.sv
// tb: self-checking bench for the byte-mode bus handover dma
// assumes dbh_host_model on the far side; inputs change at falling edges
`timescale 1ns/1ns
module tb;
  logic                  sys_clk, reset, dir_tx, match_hi, ready_n;
  logic [15:0]           match_word;
  logic                  bus_hold_grant_n, bus_hold_request_n;
  logic [15:0]           addr_o;
  logic                  addr_oe, data_oe, strobes_oe, byte_done, match_hit;
  logic [7:0]            data_i, data_o;
  dbh_pkg::dbh_strobes_t strobes_o;
  int                    cycle_len, err_count, checks;
  localparam logic [15:0] IO_ADDR = 16'h8021;    // fixed port address
  localparam logic [15:0] MEM_START = 16'h1200;  // first memory address

  dbh_dma i_dbh_dma (.sys_clk(sys_clk), .reset(reset), .dir_tx(dir_tx), .mem_addr_start(MEM_START),
    .io_addr(IO_ADDR), .match_word(match_word), .match_hi(match_hi), .ready_n(ready_n),
    .bus_hold_grant_n(bus_hold_grant_n), .bus_hold_request_n(bus_hold_request_n), .addr_o(addr_o),
    .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .strobes_o(strobes_o),
    .strobes_oe(strobes_oe), .byte_done(byte_done), .match_hit(match_hit));
  dbh_host_model i_dbh_host_model (.sys_clk(sys_clk), .cycle_len(cycle_len),
    .bus_hold_request_n(bus_hold_request_n), .bus_hold_grant_n(bus_hold_grant_n), .addr_o(addr_o),
    .strobes_o(strobes_o), .strobes_oe(strobes_oe), .data_i(data_i));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // event codes: 0 read strobe, 1 write strobe, 2 request off, 3 request on, 4 floated
  function automatic logic hit(input int c);
    case (c)
      0: return strobes_oe === 1'b1 && strobes_o.rd_n === 1'b0;
      1: return strobes_o.wr_n === 1'b0;
      2: return bus_hold_request_n === 1'b1;
      3: return bus_hold_request_n === 1'b0;
      default: return strobes_oe === 1'b0;
    endcase
  endfunction

  task automatic wait_on(input int c, output int n);
    n = 0;
    while (!hit(c) && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // one whole byte with ready held low after it, then released
  task automatic run_byte(input logic tx, input logic [15:0] maddr, input logic [7:0] dexp, input logic mexp);
    int n;
    dir_tx = tx;
    ready_n = 1'b0;
    wait_on(3, n);
    chk(16'(n), 16'(2 + dbh_pkg::RDY_TO_REQ));
    chk({addr_oe, data_oe, strobes_oe}, 3'h0);
    wait_on(0, n);
    chk(16'(n), 16'(cycle_len + 3 + dbh_pkg::ACK_TO_FIRST));
    chk({strobes_o.memory_cycle_strobe_n, strobes_o.io_cycle_strobe_n}, tx ? 2'h1 : 2'h2);
    chk(addr_o, tx ? maddr : IO_ADDR);
    wait_on(1, n);
    chk(16'(n), tx ? 16'(dbh_pkg::TX_RD_TO_WR) : 16'(dbh_pkg::RX_RD_TO_WR));
    chk({strobes_o.memory_cycle_strobe_n, strobes_o.io_cycle_strobe_n}, tx ? 2'h2 : 2'h1);
    chk(addr_o, tx ? IO_ADDR : maddr);
    chk({data_oe, data_o}, {1'b1, dexp});
    wait_on(2, n);
    chk(16'(n), tx ? 16'(dbh_pkg::TX_WR_TO_DROP) : 16'(dbh_pkg::RX_WR_TO_DROP));
    wait_on(4, n);
    chk(16'(n), 16'(dbh_pkg::DROP_TO_END));
    chk({byte_done, addr_oe, data_oe}, 3'h4);
    @(negedge sys_clk);
    chk(match_hit, mexp);
    chk(byte_done, 1'b0);
    repeat (8) @(negedge sys_clk);
    chk(bus_hold_request_n, 1'b1);
    ready_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset_idle;
    chk({bus_hold_request_n, addr_oe, data_oe, strobes_oe, byte_done}, 5'h10);
    chk(strobes_o, 4'hf);
    $display("test reset_idle done");
  endtask

  task automatic t_rx;
    cycle_len = 1;
    match_word = 16'h3c00;
    match_hi = 1'b1;
    run_byte(1'b0, 16'h1200, 8'h3c, 1'b1);
    $display("test rx done");
  endtask

  task automatic t_tx_pair;
    cycle_len = 5;
    match_word = 16'h3c00;
    match_hi = 1'b0;
    run_byte(1'b1, 16'h1201, 8'h5b, 1'b0);
    match_word = 16'h0058;
    run_byte(1'b1, 16'h1202, 8'h58, 1'b1);
    $display("test tx_pair done");
  endtask

  task automatic t_mid_reset;
    int n;
    cycle_len = 2;
    dir_tx = 1'b0;
    ready_n = 1'b0;
    wait_on(0, n);
    reset = 1'b1;
    ready_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({bus_hold_request_n, addr_oe, data_oe, strobes_oe}, 4'h8);
    reset = 1'b0;
    repeat (6) @(negedge sys_clk);
    match_word = 16'h3c00;
    match_hi = 1'b1;
    run_byte(1'b0, 16'h1200, 8'h3c, 1'b1);
    $display("test mid_reset done");
  endtask

  // ==========================================================
  // run control
  // ==========================================================
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end

  initial begin
    err_count = 0;
    checks = 0;
    reset = 1'b1;
    dir_tx = 1'b0;
    ready_n = 1'b1;
    match_word = 16'h0000;
    match_hi = 1'b0;
    cycle_len = 1;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset_idle();
    t_rx();
    t_tx_pair();
    t_mid_reset();
    end_sim();
  end
endmodule

//--- rtl/dbh_dma.sv
// dbh_dma: single-channel byte-mode dma that borrows the system bus per byte
// assumes host grants the bus over a hold request / grant pair, one clock
//
// Functional notes
// (RL1) active-low ready, one byte per activation
// (RL2) hold request two clocks after ready
// (RL3) host grants one clock after its cycle
// (RL4) receive: io read +4, memory write +4
// (RL5) receive: drop request +2, write ends +1
// (RL6) host releases grant one clock after end
// (RL7) transmit: memory read +4, io write +3
// (RL8) transmit: drop request +3, write ends +1
// (RL9) at most thirteen bus periods per byte
// (RL10) host floats bus while we hold it
// (RL11) byte data, sixteen-bit addresses
// (RL12) search compares one byte from either half
// (RL13) float outputs outside granted window
`timescale 1ns/1ns
module dbh_dma (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // transfer set-up from local logic
  input  wire logic                  dir_tx,          // 1 memory->io, 0 io->memory
  input  wire logic [15:0]           mem_addr_start,  // first memory address
  input  wire logic [15:0]           io_addr,         // peripheral port address
  input  wire logic [15:0]           match_word,      // search pattern source
  input  wire logic                  match_hi,        // pick upper byte of pattern
  // peripheral ready pin
  input  wire logic                  ready_n,
  // host handshake
  input  wire logic                  bus_hold_grant_n,
  output logic                       bus_hold_request_n,
  // system bus, value and enable per shared pin, plus data input
  output logic [15:0]                addr_o,
  output logic                       addr_oe,
  input  wire logic [7:0]            data_i,
  output logic [7:0]                 data_o,
  output logic                       data_oe,
  output dbh_pkg::dbh_strobes_t      strobes_o,
  output logic                       strobes_oe,
  // status
  output logic                       byte_done,       // one-cycle pulse per byte
  output logic                       match_hit        // last byte equalled pattern
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic rdy_m_r, rdy_s_r, ack_m_r, ack_s_r;  // two stages each
  logic rdy_m_nxt, rdy_s_nxt, ack_m_nxt, ack_s_nxt;

  // pins are asynchronous to our clock
  always_comb begin
    rdy_m_nxt = ~ready_n;
    rdy_s_nxt = rdy_m_r;
    ack_m_nxt = ~bus_hold_grant_n;
    ack_s_nxt = ack_m_r;
  end

  // register the synchronisers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdy_m_r <= 1'b0;
      rdy_s_r <= 1'b0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      rdy_m_r <= rdy_m_nxt;
      rdy_s_r <= rdy_s_nxt;
      ack_m_r <= ack_m_nxt;
      ack_s_r <= ack_s_nxt;
    end
  end

  // ==========================================================
  // search byte selection
  // ==========================================================
  // one byte from either half, never the full word
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // ==========================================================
  // transfer sequencer
  // ==========================================================
  dbh_pkg::dbh_state_t   st_r, st_nxt;       // sequencer state
  logic [3:0]            cnt_r, cnt_nxt;     // period counter
  logic                  armed_r, armed_nxt; // ready seen, waiting for release
  logic                  req_n_r, req_n_nxt; // hold request pin, active low
  logic                  started_r, started_nxt; // a byte has completed since reset
  logic [15:0]           cur_ma;             // memory address of this byte
  logic [15:0]           maddr_r, maddr_nxt; // running memory address
  logic [7:0]            dat_r, dat_nxt;     // byte in flight
  logic [15:0]           ad_r, ad_nxt;       // address pins
  logic                  aoe_r, aoe_nxt;     // address enable
  logic [7:0]            do_r, do_nxt;       // data pins
  logic                  doe_r, doe_nxt;     // data enable
  dbh_pkg::dbh_strobes_t sb_r, sb_nxt;       // strobes
  logic                  soe_r, soe_nxt;     // strobe enable
  logic                  done_r, done_nxt;   // byte pulse
  logic                  hit_r, hit_nxt;     // match flag
  logic [3:0]            t_rd, t_wr, t_drop; // phase marks per direction

  // phase marks counted from grant seen (cnt 0)
  always_comb begin
    t_rd   = 4'(dbh_pkg::ACK_TO_FIRST);
    cur_ma = started_r ? maddr_r : mem_addr_start; // start address until a byte ends
    t_wr   = dir_tx ? 4'(dbh_pkg::ACK_TO_FIRST + dbh_pkg::TX_RD_TO_WR)
                    : 4'(dbh_pkg::ACK_TO_FIRST + dbh_pkg::RX_RD_TO_WR);
    t_drop = dir_tx ? 4'(dbh_pkg::ACK_TO_FIRST + dbh_pkg::TX_RD_TO_WR + dbh_pkg::TX_WR_TO_DROP)
                    : 4'(dbh_pkg::ACK_TO_FIRST + dbh_pkg::RX_RD_TO_WR + dbh_pkg::RX_WR_TO_DROP);
  end

  // next-state logic
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    armed_nxt = armed_r;
    req_n_nxt = req_n_r;
    started_nxt = started_r | done_r;        // latch first completion
    maddr_nxt = maddr_r;
    dat_nxt   = dat_r;
    ad_nxt    = ad_r;
    aoe_nxt   = aoe_r;
    do_nxt    = do_r;
    doe_nxt   = doe_r;
    sb_nxt    = sb_r;
    soe_nxt   = soe_r;
    done_nxt  = 1'b0;
    hit_nxt   = hit_r;
    if (!rdy_s_r) begin
      armed_nxt = 1'b0;                      // ready released, rearm
    end
    case (st_r)
      dbh_pkg::DBH_IDLE: begin
        // new activation only, one byte each RL1
        if (rdy_s_r && !armed_r) begin
          armed_nxt = 1'b1;
          cnt_nxt   = dbh_pkg::CNT_RST;
          st_nxt    = dbh_pkg::DBH_WAIT_REQ;
        end
      end
      dbh_pkg::DBH_WAIT_REQ: begin
        // request two periods after ready RL2
        if (cnt_r == 4'(dbh_pkg::RDY_TO_REQ - 2)) begin
          req_n_nxt = 1'b0;
          st_nxt  = dbh_pkg::DBH_WAIT_ACK;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      dbh_pkg::DBH_WAIT_ACK: begin
        // host grants when its cycle ends RL3
        if (ack_s_r) begin
          cnt_nxt = 4'h1;
          st_nxt  = dbh_pkg::DBH_XFER;
          aoe_nxt = 1'b1;                    // drive only once granted RL13
          soe_nxt = 1'b1;
          sb_nxt  = dbh_pkg::STROBES_IDLE;
        end
      end
      dbh_pkg::DBH_XFER: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == t_rd - 4'h1) begin
          // first (read) cycle begins RL4 RL7
          sb_nxt.rd_n = 1'b0;
          if (dir_tx) begin
            ad_nxt = cur_ma;                 // RL11
            sb_nxt.memory_cycle_strobe_n = 1'b0;
          end else begin
            ad_nxt = io_addr;
            sb_nxt.io_cycle_strobe_n = 1'b0;
          end
        end
        if (cnt_r == t_wr - 4'h1) begin
          // capture read byte, start write cycle RL4 RL7
          dat_nxt = data_i;
          hit_nxt = (data_i == pick_byte(match_word, match_hi)); // RL12
          sb_nxt  = dbh_pkg::STROBES_IDLE;
          sb_nxt.wr_n = 1'b0;
          do_nxt  = data_i;
          doe_nxt = 1'b1;
          if (dir_tx) begin
            ad_nxt = io_addr;
            sb_nxt.io_cycle_strobe_n = 1'b0;
          end else begin
            ad_nxt = cur_ma;
            sb_nxt.memory_cycle_strobe_n = 1'b0;
          end
        end
        if (cnt_r == t_drop - 4'h1) begin
          req_n_nxt = 1'b1;                  // drop request RL5 RL8
        end
        if (cnt_r == t_drop + 4'(dbh_pkg::DROP_TO_END) - 4'h1) begin
          // write ends, release bus RL5 RL6 RL8 RL13
          sb_nxt    = dbh_pkg::STROBES_IDLE;
          aoe_nxt   = 1'b0;
          doe_nxt   = 1'b0;
          soe_nxt   = 1'b0;
          maddr_nxt = cur_ma + 16'h0001;
          done_nxt  = 1'b1;
          st_nxt    = dbh_pkg::DBH_IDLE;
        end
      end
      default: begin
        st_nxt = dbh_pkg::DBH_IDLE;
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r    <= dbh_pkg::DBH_IDLE;
      cnt_r   <= dbh_pkg::CNT_RST;
      armed_r <= 1'b0;
      req_n_r <= 1'b1;
      started_r <= 1'b0;
      maddr_r <= dbh_pkg::ADDR_RST;
      dat_r   <= dbh_pkg::DATA_RST;
      ad_r    <= dbh_pkg::ADDR_RST;
      aoe_r   <= 1'b0;
      do_r    <= dbh_pkg::DATA_RST;
      doe_r   <= 1'b0;
      sb_r    <= dbh_pkg::STROBES_IDLE;
      soe_r   <= 1'b0;
      done_r  <= 1'b0;
      hit_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      armed_r <= armed_nxt;
      req_n_r <= req_n_nxt;
      started_r <= started_nxt;
      maddr_r <= maddr_nxt;
      dat_r   <= dat_nxt;
      ad_r    <= ad_nxt;
      aoe_r   <= aoe_nxt;
      do_r    <= do_nxt;
      doe_r   <= doe_nxt;
      sb_r    <= sb_nxt;
      soe_r   <= soe_nxt;
      done_r  <= done_nxt;
      hit_r   <= hit_nxt;
    end
  end

  // ==========================================================
  // outputs, straight from flip-flops
  // ==========================================================
  always_comb begin
    bus_hold_request_n = req_n_r;
    addr_o     = ad_r;
    addr_oe    = aoe_r;
    data_o     = do_r;
    data_oe    = doe_r;
    strobes_o  = sb_r;
    strobes_oe = soe_r;
    byte_done  = done_r;
    match_hit  = hit_r;
  end

  // ==========================================================
  // assertions
  // ==========================================================
  int unsigned occ_r;                        // periods bus held by us
  always_ff @(posedge sys_clk) begin
    if (reset || !aoe_r) occ_r <= 0;
    else occ_r <= occ_r + 1;
  end

  sequence s_req_rise;
    $fell(bus_hold_request_n);
  endsequence

  property p_req_after_ready;
    @(posedge sys_clk) disable iff (reset)
      (st_r == dbh_pkg::DBH_IDLE && rdy_s_r && !armed_r) |-> ##2 s_req_rise;
  endproperty
  a_req_after_ready: assert property (p_req_after_ready) else $error("request late"); // RL2

  property p_rx_read;
    @(posedge sys_clk) disable iff (reset)
      (st_r == dbh_pkg::DBH_WAIT_ACK && ack_s_r && !dir_tx) |-> ##4 !strobes_o.io_cycle_strobe_n && !strobes_o.rd_n;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx read start wrong"); // RL4

  property p_rx_write;
    @(posedge sys_clk) disable iff (reset)
      $fell(strobes_o.rd_n) && !dir_tx |-> ##4 !strobes_o.memory_cycle_strobe_n && !strobes_o.wr_n;
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("rx write start wrong"); // RL4

  property p_rx_drop;
    @(posedge sys_clk) disable iff (reset)
      $fell(strobes_o.wr_n) && !dir_tx |-> ##2 $rose(bus_hold_request_n) ##1 strobes_o.wr_n;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx drop wrong"); // RL5

  property p_tx_read;
    @(posedge sys_clk) disable iff (reset)
      (st_r == dbh_pkg::DBH_WAIT_ACK && ack_s_r && dir_tx) |-> ##4 !strobes_o.memory_cycle_strobe_n ##3 !strobes_o.wr_n;
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("tx cycles wrong"); // RL7

  property p_tx_drop;
    @(posedge sys_clk) disable iff (reset)
      $fell(strobes_o.wr_n) && dir_tx |-> ##3 $rose(bus_hold_request_n) ##1 strobes_o.wr_n;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("tx drop wrong"); // RL8

  property p_occupancy;
    @(posedge sys_clk) disable iff (reset) occ_r <= dbh_pkg::MAX_OCCUPANCY;
  endproperty
  a_occupancy: assert property (p_occupancy) else $error("bus held too long"); // RL9

  property p_float;
    @(posedge sys_clk) disable iff (reset)
      (st_r != dbh_pkg::DBH_XFER) |-> !data_oe && (!addr_oe || done_r);
  endproperty
  a_float: assert property (p_float) else $error("driving outside grant"); // RL13

  property p_one_byte;
    @(posedge sys_clk) disable iff (reset)
      byte_done |-> ##1 (st_r == dbh_pkg::DBH_IDLE) ##1 !byte_done;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("extra byte"); // RL1

  property p_match;
    @(posedge sys_clk) disable iff (reset)
      $fell(strobes_o.wr_n) |-> (match_hit == (data_o == (match_hi ? match_word[15:8] : match_word[7:0])));
  endproperty
  a_match: assert property (p_match) else $error("match check"); // RL12

endmodule

//--- rtl/dbh_pkg.sv
// dbh_pkg: constants and carrier types for the byte-mode bus handover dma
// assumes a single 20 MHz system clock; no software-visible registers
package dbh_pkg;

  // ==========================================================
  // clock and timing counts (in clock periods)
  // ==========================================================
  localparam int CLK_PERIOD_NS  = 50;        // 20 MHz system clock
  localparam int RDY_TO_REQ     = 2;         // ready active to hold request
  localparam int ACK_TO_FIRST   = 4;         // grant to first cycle start
  localparam int RX_RD_TO_WR    = 4;         // io read start to mem write start
  localparam int RX_WR_TO_DROP  = 2;         // mem write start to request drop
  localparam int TX_RD_TO_WR    = 3;         // mem read start to io write start
  localparam int TX_WR_TO_DROP  = 3;         // io write start to request drop
  localparam int DROP_TO_END    = 1;         // request drop to write end
  localparam int MAX_OCCUPANCY  = 13;        // bus periods per byte, ceiling

  // ==========================================================
  // widths and reset values
  // ==========================================================
  localparam int ADDR_W = 16;                // full 64 kbyte reach
  localparam int DATA_W = 8;                 // byte transfers
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [3:0]  CNT_RST  = 4'h0;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [1:0] {
    DBH_IDLE,
    DBH_WAIT_REQ,
    DBH_WAIT_ACK,
    DBH_XFER
  } dbh_state_t;

  // bus strobes, active low on the pins
  typedef struct packed {
    logic memory_cycle_strobe_n;
    logic io_cycle_strobe_n;
    logic rd_n;
    logic wr_n;
  } dbh_strobes_t;

  localparam dbh_strobes_t STROBES_IDLE = 4'hf;

endpackage
